// *** verilog/rxcc_pkg.sv ***
// Purpose: constants and types of the receive control-cell capture block
// Assumes: 16-bit direct register port, one byte per cycle cell stream
// Notes:   definitions only
package rxcc_pkg;
  localparam int unsigned N_LINK     = 16;
  localparam int unsigned LINK_W     = 4;
  localparam int unsigned ADDR_W     = 9;
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned CELL_BYTES = 53;
  localparam int unsigned SLOTS      = 4;
  localparam int unsigned SLOT_W     = 2;
  localparam int unsigned DIFF_DEPTH = 64;
  localparam int unsigned DIFF_PW    = 7;
  localparam int unsigned MEM_W      = 12;
  localparam int unsigned DBG_W      = 6;
  localparam int unsigned DBG_EN     = 0;
  localparam int unsigned DBG_SCOPE  = 1;

  localparam logic [ADDR_W-1:0] A_TYPE_LO   = 9'h100;
  localparam logic [ADDR_W-1:0] A_TYPE_HI   = 9'h101;
  localparam logic [ADDR_W-1:0] A_DIFF_EN   = 9'h102;
  localparam logic [ADDR_W-1:0] A_ADVANCE   = 9'h105;
  localparam logic [ADDR_W-1:0] A_STATUS    = 9'h106;
  localparam logic [ADDR_W-1:0] A_NEMPTY    = 9'h107;
  localparam logic [ADDR_W-1:0] A_DEBUG     = 9'h108;
  localparam logic [ADDR_W-1:0] A_DIFF_BASE = 9'h140;

  localparam logic [DATA_W-1:0] REG_RST  = 16'h0000;
  localparam logic [5:0]        CELL_LEN = 6'h35;
  localparam logic [5:0]        HDR_LEN  = 6'h05;
  localparam logic [5:0]        OFF_ONE  = 6'h01;

  typedef enum logic [1:0] {
    MODE_ICP_CHG = 2'h0,
    MODE_ICP_ALL = 2'h1,
    MODE_ALL     = 2'h2,
    MODE_NONE    = 2'h3
  } rxcc_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_BODY = 2'h1
  } rxcc_state_t;

  function automatic rxcc_mode_t rxcc_link_mode(input logic [31:0] types, input logic [LINK_W-1:0] link);
    return rxcc_mode_t'(types[{link, 1'b0} +: 2]);
  endfunction

  function automatic logic [MEM_W-1:0] rxcc_cell_idx(input logic [LINK_W-1:0] link,
                                                     input logic [SLOT_W-1:0] slot,
                                                     input logic [5:0]        off);
    return MEM_W'({link, slot}) * MEM_W'(CELL_BYTES) + MEM_W'(off) - MEM_W'(OFF_ONE);
  endfunction
endpackage

// *** verilog/rxcc_diff_if.sv ***
// Purpose: carrier between capture logic and the difference fifo
// Assumes: one accepted byte per cycle at most
// Notes:   ctl drives pushes and pops, fifo answers with the head word
`timescale 1ns/100ps
`default_nettype none
interface rxcc_diff_if;
  import rxcc_pkg::*;
  logic              byte_en;
  logic              first;
  logic              push;
  logic              commit;
  logic              abort;
  logic [LINK_W-1:0] wlink;
  logic [13:0]       entry;
  logic              pop;
  logic [LINK_W-1:0] rlink;
  logic [DATA_W-1:0] rword;
  logic [N_LINK-1:0] nempty;
  modport ctl  (output byte_en, first, push, commit, abort, wlink, entry, pop, rlink, input rword, nempty);
  modport fifo (input byte_en, first, push, commit, abort, wlink, entry, pop, rlink, output rword, nempty);
endinterface
`default_nettype wire

// *** verilog/rxcc_ptr_ring.sv ***
// Purpose: per-link slot pointers of the four-slot cell fifo
// Assumes: commit arrives only while not full
// Notes:   one slot stays free so a 2-bit level never aliases
`timescale 1ns/100ps
`default_nettype none
module rxcc_ptr_ring
  import rxcc_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              arst_n,
  input  wire logic              commit,
  input  wire logic              adv,
  output logic      [SLOT_W-1:0] wptr,
  output logic      [SLOT_W-1:0] rptr,
  output logic      [SLOT_W-1:0] level,
  output logic                   full
);
  logic [SLOT_W-1:0] wptr_q;
  logic [SLOT_W-1:0] rptr_q;

  assign wptr  = wptr_q;
  assign rptr  = rptr_q;
  assign level = wptr_q - rptr_q;
  assign full  = level == SLOT_W'(SLOTS - 1);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wptr_q <= '0;
      rptr_q <= '0;
    end else begin
      if (commit && !full)
        wptr_q <= wptr_q + 1'b1;
      if (adv && level != '0)
        rptr_q <= rptr_q + 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** verilog/rxcc_diff_fifo.sv ***
// Purpose: per-link fifo of changed bytes, staged until the cell commits
// Assumes: bytes of one cell arrive without interleaving
// Notes:   entries of a dropped cell are rolled back, never seen by software
`timescale 1ns/100ps
`default_nettype none
module rxcc_diff_fifo
  import rxcc_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic arst_n,
  rxcc_diff_if.fifo dif
);
  localparam int unsigned DN = N_LINK * DIFF_DEPTH;

  logic [13:0]        mem_q  [0:DN-1];
  logic               last_q [0:DN-1];
  logic [DIFF_PW-1:0] wc_q   [N_LINK];
  logic [DIFF_PW-1:0] wt_q   [N_LINK];
  logic [DIFF_PW-1:0] rp_q   [N_LINK];

  function automatic logic [9:0] slot(input logic [LINK_W-1:0] l, input logic [DIFF_PW-1:0] p);
    return {l, p[DIFF_PW-2:0]};
  endfunction

  wire [DIFF_PW-1:0] wbase   = dif.first ? wc_q[dif.wlink] : wt_q[dif.wlink];
  wire               can_put = (wbase - rp_q[dif.wlink]) != DIFF_PW'(DIFF_DEPTH);
  wire               put     = dif.push && can_put;
  wire [DIFF_PW-1:0] wnext   = put ? wbase + 1'b1 : wbase;
  wire [DIFF_PW-1:0] rlev    = wc_q[dif.rlink] - rp_q[dif.rlink];
  wire [DIFF_PW-1:0] rhead   = rp_q[dif.rlink];

  assign dif.rword = (rlev == '0) ? REG_RST :
                     {rlev > DIFF_PW'(1), last_q[slot(dif.rlink, rhead)], mem_q[slot(dif.rlink, rhead)]};

  for (genvar g = 0; g < N_LINK; g++) begin : g_ne
    assign dif.nempty[g] = wc_q[g] != rp_q[g];
  end

  always_ff @(posedge ref_clk) begin
    if (put) begin
      mem_q[slot(dif.wlink, wbase)]  <= dif.entry;
      last_q[slot(dif.wlink, wbase)] <= 1'b0;
    end
    if (dif.commit && wnext != wc_q[dif.wlink])
      last_q[slot(dif.wlink, wnext - 1'b1)] <= 1'b1;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < N_LINK; i++) begin
        wc_q[i] <= '0;
        wt_q[i] <= '0;
        rp_q[i] <= '0;
      end
    end else begin
      if (dif.byte_en) begin
        wt_q[dif.wlink] <= dif.abort ? wc_q[dif.wlink] : wnext;
        if (dif.commit)
          wc_q[dif.wlink] <= wnext;
      end
      if (dif.pop && rlev != '0)
        rp_q[dif.rlink] <= rp_q[dif.rlink] + 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** verilog/rxcc_capture.sv ***
// Purpose: receive control-cell capture, compare and register port
// Assumes: cell bytes 1..53 per cell, ok and icp qualifiers valid on last byte
// Notes:   read data returns one cycle after the read strobe
`timescale 1ns/100ps
`default_nettype none
module rxcc_capture
  import rxcc_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              arst_n,
  input  wire logic              cpu_cs,
  input  wire logic              cpu_wr,
  input  wire logic              cpu_rd,
  input  wire logic [ADDR_W-1:0] cpu_addr,
  input  wire logic [DATA_W-1:0] cpu_wdata,
  output logic      [DATA_W-1:0] cpu_rdata,
  output logic                   cpu_rvalid,
  input  wire logic              cell_vld,
  input  wire logic              cell_first,
  input  wire logic              cell_last,
  input  wire logic [LINK_W-1:0] cell_link,
  input  wire logic [7:0]        cell_byte,
  input  wire logic              cell_ok,
  input  wire logic              cell_icp
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] type_lo_q;
  logic [DATA_W-1:0] type_hi_q;
  logic [DATA_W-1:0] diff_en_q;
  logic [LINK_W-1:0] sel_q;
  logic [DBG_W-1:0]  dbg_q;
  logic [DATA_W-1:0] rdata_q;
  logic              rvalid_q;

  wire wr_en   = cpu_cs && cpu_wr;
  wire rd_en   = cpu_cs && cpu_rd;
  wire wr_lo   = wr_en && cpu_addr == A_TYPE_LO;
  wire wr_hi   = wr_en && cpu_addr == A_TYPE_HI;
  wire wr_den  = wr_en && cpu_addr == A_DIFF_EN;
  wire wr_adv  = wr_en && cpu_addr == A_ADVANCE;
  wire wr_sel  = wr_en && cpu_addr == A_STATUS;
  wire wr_dbg  = wr_en && cpu_addr == A_DEBUG;
  wire rd_stat = rd_en && cpu_addr == A_STATUS;
  wire rd_nemp = rd_en && cpu_addr == A_NEMPTY;
  wire rd_diff = rd_en && cpu_addr[ADDR_W-1:LINK_W] == A_DIFF_BASE[ADDR_W-1:LINK_W];

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      type_lo_q <= REG_RST;
      type_hi_q <= REG_RST;
      diff_en_q <= REG_RST;
      sel_q     <= '0;
      dbg_q     <= '0;
    end else begin
      if (wr_lo)
        type_lo_q <= cpu_wdata;
      if (wr_hi)
        type_hi_q <= cpu_wdata;
      if (wr_den)
        diff_en_q <= cpu_wdata;
      if (wr_sel)
        sel_q <= cpu_wdata[LINK_W-1:0];
      if (wr_dbg)
        dbg_q <= cpu_wdata[DBG_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // per-link slot pointers
  // ----------------------------------------------------------------
  logic [SLOT_W-1:0] wp [N_LINK];
  logic [SLOT_W-1:0] rp [N_LINK];
  logic [SLOT_W-1:0] lv [N_LINK];
  logic [N_LINK-1:0] full;
  logic [N_LINK-1:0] commit_vec;

  // zero bits of the advance word leave their pointer alone
  wire [N_LINK-1:0] adv_vec = wr_adv ? cpu_wdata : REG_RST;

  for (genvar g = 0; g < N_LINK; g++) begin : g_ring
    rxcc_ptr_ring u_ring (
      .ref_clk (ref_clk),
      .arst_n  (arst_n),
      .commit  (commit_vec[g]),
      .adv     (adv_vec[g]),
      .wptr    (wp[g]),
      .rptr    (rp[g]),
      .level   (lv[g]),
      .full    (full[g])
    );
  end

  // ----------------------------------------------------------------
  // cell stream tracking
  // ----------------------------------------------------------------
  rxcc_state_t       st_q;
  rxcc_state_t       st_d;
  logic [LINK_W-1:0] link_q;
  logic [5:0]        off_q;
  logic              chg_q;
  logic              over_q;
  logic              chg_d;

  wire              byte_acc = cell_vld && (cell_first || st_q == ST_BODY);
  wire [LINK_W-1:0] blink    = cell_first ? cell_link : link_q;
  wire [5:0]        byte_off = cell_first ? OFF_ONE : off_q + OFF_ONE;
  wire              off_ok   = byte_off != '0 && byte_off <= CELL_LEN;
  wire              over_d   = !cell_first && (over_q || !off_ok);

  always_comb begin
    case (st_q)
      ST_IDLE: st_d = (byte_acc && !cell_last) ? ST_BODY : ST_IDLE;
      ST_BODY: st_d = (byte_acc && cell_last) ? ST_IDLE : ST_BODY;
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q   <= ST_IDLE;
      link_q <= '0;
      off_q  <= '0;
      chg_q  <= 1'b0;
      over_q <= 1'b0;
    end else begin
      st_q <= st_d;
      if (byte_acc) begin
        link_q <= blink;
        off_q  <= byte_off;
        chg_q  <= chg_d;
        over_q <= over_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // cell store and byte compare
  // ----------------------------------------------------------------
  logic [7:0]              cell_mem [0:N_LINK*SLOTS*CELL_BYTES-1];
  logic [N_LINK*SLOTS-1:0] slot_vld_q;

  wire [SLOT_W-1:0] prev_slot = wp[blink] - 1'b1;
  wire [MEM_W-1:0]  wr_idx    = off_ok ? rxcc_cell_idx(blink, wp[blink], byte_off) : '0;
  wire [MEM_W-1:0]  pv_idx    = off_ok ? rxcc_cell_idx(blink, prev_slot, byte_off) : '0;
  // a slot never filled compares as zeros, so stale memory never leaks in
  wire [7:0]        prev_byte = slot_vld_q[{blink, prev_slot}] ? cell_mem[pv_idx] : 8'h00;
  wire              icp_scope = dbg_q[DBG_EN] && dbg_q[DBG_SCOPE];
  wire              in_scope  = !icp_scope || byte_off > HDR_LEN;
  wire              differ    = off_ok && in_scope && cell_byte != prev_byte;
  assign chg_d = differ || (!cell_first && chg_q);

  // the slot at the write pointer is always free, so writing early is safe
  always_ff @(posedge ref_clk) begin
    if (byte_acc && off_ok)
      cell_mem[wr_idx] <= cell_byte;
  end

  // ----------------------------------------------------------------
  // store decision per capture type
  // ----------------------------------------------------------------
  wire rxcc_mode_t mode = rxcc_link_mode({type_hi_q, type_lo_q}, blink);
  wire allow = (mode == MODE_ICP_CHG && cell_icp && chg_d) ||
               (mode == MODE_ICP_ALL && cell_icp) ||
               (mode == MODE_ALL);
  wire cell_end    = byte_acc && cell_last;
  wire commit_cell = cell_end && cell_ok && byte_off == CELL_LEN && !over_q && allow && !full[blink];

  assign commit_vec = commit_cell ? (N_LINK'(1) << blink) : REG_RST;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n)
      slot_vld_q <= '0;
    else if (commit_cell)
      slot_vld_q[{blink, wp[blink]}] <= 1'b1;
  end

  // ----------------------------------------------------------------
  // difference fifo
  // ----------------------------------------------------------------
  rxcc_diff_if dif ();

  assign dif.byte_en = byte_acc;
  assign dif.first   = cell_first;
  assign dif.push    = byte_acc && differ && diff_en_q[blink];
  assign dif.commit  = commit_cell;
  assign dif.abort   = cell_end && !commit_cell;
  assign dif.wlink   = blink;
  assign dif.entry   = {byte_off, cell_byte};
  assign dif.pop     = rd_diff;
  assign dif.rlink   = cpu_addr[LINK_W-1:0];

  rxcc_diff_fifo u_diff (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .dif     (dif)
  );

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  wire [DATA_W-1:0] stat_word = DATA_W'({lv[sel_q], wp[sel_q], rp[sel_q]});
  wire [DATA_W-1:0] rd_mux = (cpu_addr == A_TYPE_LO) ? type_lo_q :
                             (cpu_addr == A_TYPE_HI) ? type_hi_q :
                             (cpu_addr == A_DIFF_EN) ? diff_en_q :
                             rd_stat                 ? stat_word :
                             rd_nemp                 ? dif.nempty :
                             (cpu_addr == A_DEBUG)   ? DATA_W'(dbg_q) :
                             rd_diff                 ? dif.rword : REG_RST;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q  <= REG_RST;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= rd_en;
      if (rd_en)
        rdata_q <= rd_mux;
    end
  end

  assign cpu_rdata  = rdata_q;
  assign cpu_rvalid = rvalid_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [LINK_W-1:0] chk_link_q;
  logic [SLOT_W-1:0] chk_wp_q;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      chk_link_q <= '0;
      chk_wp_q   <= '0;
    end else begin
      chk_link_q <= blink;
      chk_wp_q   <= wp[blink];
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  a_type_hi_link8: assert property (wr_hi |=> rxcc_link_mode({type_hi_q, type_lo_q}, 4'h8) == $past(cpu_wdata[1:0]))
    else $error("link 8 capture type not in low bits");
  a_commit_steps_wp: assert property (commit_cell |=> wp[chk_link_q] == chk_wp_q + 2'h1)
    else $error("stored cell did not advance write pointer");
  a_none_no_store: assert property (mode == MODE_NONE && byte_acc |-> !commit_cell ##1 wp[chk_link_q] == chk_wp_q)
    else $error("cell stored while capture type is none");
  a_push_needs_en: assert property (dif.push |-> diff_en_q[blink] && cell_byte != prev_byte)
    else $error("difference pushed without enable or change");
  a_adv_zero_hold: assert property (wr_adv && !cpu_wdata[0] && !commit_vec[0] |=> $stable(rp[0]))
    else $error("read pointer moved on a zero advance bit");
  a_adv_one_step: assert property (wr_adv && cpu_wdata[0] && lv[0] != 2'h0 |=> rp[0] == $past(rp[0]) + 2'h1)
    else $error("read pointer did not advance");
  a_sel_next_read: assert property (wr_sel ##1 rd_stat |-> sel_q == $past(cpu_wdata[3:0]))
    else $error("status selection not used on next read");
  a_stat_fields: assert property (rd_stat |=> cpu_rdata[5:4] == cpu_rdata[3:2] - cpu_rdata[1:0])
    else $error("status level disagrees with pointers");
  a_upper_zero: assert property ((rd_stat || (rd_en && cpu_addr == A_DEBUG)) |=> cpu_rdata[15:6] == 10'h000)
    else $error("unused status or debug bits not zero");
  a_nempty_read: assert property (rd_nemp |=> cpu_rvalid && cpu_rdata == $past(dif.nempty))
    else $error("not-empty readback wrong");
  a_scope_skip_hdr: assert property (dif.push && dbg_q[DBG_EN] && dbg_q[DBG_SCOPE] |-> byte_off > HDR_LEN)
    else $error("header byte compared in icp scope");
  a_diff_offset: assert property (rd_diff |=> cpu_rdata == 16'h0000 || cpu_rdata[13:8] inside {[1:53]})
    else $error("difference offset out of range");
endmodule
`default_nettype wire

// *** test/rxcc_tb.sv ***
// Purpose: self-checking bench for the receive control-cell capture block
// Assumes: read data one cycle after the strobe, store decided on byte 53
// Notes:   bench keeps its own pointer, content and diff-queue model
`timescale 1ns/100ps
`default_nettype none
module testbench
  import rxcc_pkg::*;
;
  // ------------------------------------------------------------
  // signals and model state
  // ------------------------------------------------------------
  localparam int TMO = 50000;
  localparam logic [ADDR_W-1:0] RST_A [8] = '{A_TYPE_LO, A_TYPE_HI, A_DIFF_EN, A_ADVANCE,
                                              A_STATUS, A_NEMPTY, A_DEBUG, 9'h10F};
  logic              ref_clk    = 1'b0;
  logic              arst_n     = 1'b0;
  logic              cpu_cs     = 1'b0;
  logic              cpu_wr     = 1'b0;
  logic              cpu_rd     = 1'b0;
  logic [ADDR_W-1:0] cpu_addr   = 9'h000;
  logic [DATA_W-1:0] cpu_wdata  = 16'h0000;
  logic [DATA_W-1:0] cpu_rdata;
  logic              cpu_rvalid;
  logic              cell_vld   = 1'b0;
  logic              cell_first = 1'b0;
  logic              cell_last  = 1'b0;
  logic [LINK_W-1:0] cell_link  = 4'h0;
  logic [7:0]        cell_byte  = 8'h00;
  logic              cell_ok    = 1'b0;
  logic              cell_icp   = 1'b0;
  logic [1:0]        m_wp [N_LINK];
  logic [1:0]        m_rp [N_LINK];
  logic [7:0]        last_cell [N_LINK][1:53];
  logic [7:0]        cbuf [1:53];
  logic [14:0]       dq [N_LINK][$];
  logic [31:0]       m_types;
  logic [15:0]       m_den;
  logic [1:0]        m_dbg;
  int                n_mismatch   = 0;
  int                total_checks = 0;
  int                cyc          = 0;

  always #5 ref_clk = ~ref_clk;

  rxcc_capture uut (
    .ref_clk    (ref_clk),
    .arst_n     (arst_n),
    .cpu_cs     (cpu_cs),
    .cpu_wr     (cpu_wr),
    .cpu_rd     (cpu_rd),
    .cpu_addr   (cpu_addr),
    .cpu_wdata  (cpu_wdata),
    .cpu_rdata  (cpu_rdata),
    .cpu_rvalid (cpu_rvalid),
    .cell_vld   (cell_vld),
    .cell_first (cell_first),
    .cell_last  (cell_last),
    .cell_link  (cell_link),
    .cell_byte  (cell_byte),
    .cell_ok    (cell_ok),
    .cell_icp   (cell_icp)
  );

  // ------------------------------------------------------------
  // bus and cell tasks, all entered just after a rising edge
  // ------------------------------------------------------------
  task automatic conclude();
    if (n_mismatch == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // strobes stay up until the next access or cell sets them, so no signal changes twice in one step
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    cpu_cs = 1'b1;
    cpu_wr = 1'b1;
    cpu_rd = 1'b0;
    cpu_addr = a;
    cpu_wdata = d;
    @(posedge ref_clk);
    #1;
  endtask

  // rvalid and data land on the same edge that takes the strobe
  task automatic rdcmp(input logic [ADDR_W-1:0] a, input logic [15:0] exp);
    cpu_cs = 1'b1;
    cpu_wr = 1'b0;
    cpu_rd = 1'b1;
    cpu_addr = a;
    @(posedge ref_clk);
    #1;
    chk({15'h0000, cpu_rvalid}, 16'h0001);
    chk(cpu_rdata, exp);
  endtask

  task automatic st_chk(input int l);
    wr(A_STATUS, 16'(l));
    rdcmp(A_STATUS, {10'h000, m_wp[l] - m_rp[l], m_wp[l], m_rp[l]});
  endtask

  task automatic adv(input logic [15:0] m);
    wr(A_ADVANCE, m);
    for (int i = 0; i < 16; i++)
      if (m[i] && m_wp[i] != m_rp[i]) m_rp[i] = m_rp[i] + 2'h1;
  endtask

  task automatic ne_chk();
    logic [15:0] e;
    for (int i = 0; i < 16; i++) e[i] = dq[i].size() > 0;
    rdcmp(A_NEMPTY, e);
  endtask

  task automatic drain(input int l);
    logic        more;
    logic [14:0] ent;
    while (dq[l].size() > 0) begin
      more = dq[l].size() > 1;
      ent = dq[l].pop_front();
      rdcmp(A_DIFF_BASE + 9'(l), {more, ent});
    end
    rdcmp(A_DIFF_BASE + 9'(l), 16'h0000);
  endtask

  // two random bytes off the last stored cell keeps the diff fifo far from its 64 limit
  task automatic mk_cell(input int l);
    for (int k = 1; k <= 53; k++) cbuf[k] = last_cell[l][k];
    repeat (2) cbuf[1 + $urandom % 53] = 8'($urandom);
  endtask

  task automatic send_cell(input int l, input int nb, input logic ok, input logic icp);
    logic [1:0] md;
    logic       chg;
    logic       st;
    int         lo;
    int         n0;
    logic [14:0] ent;
    cpu_cs = 1'b0;
    cpu_wr = 1'b0;
    cpu_rd = 1'b0;
    md = m_types[2*l +: 2];
    lo = (m_dbg == 2'h3) ? 6 : 1;
    chg = 1'b0;
    for (int k = lo; k <= 53; k++) chg |= cbuf[k] != last_cell[l][k];
    st = ok && nb == 53 && md != 2'h3 && (md == 2'h2 || icp && (md == 2'h1 || chg))
         && (m_wp[l] - m_rp[l]) != 2'h3;
    for (int k = 1; k <= nb; k++) begin
      cell_vld = 1'b1;
      cell_first = k == 1;
      cell_last = k == nb;
      cell_link = 4'(l);
      cell_byte = cbuf[k];
      cell_ok = ok;
      cell_icp = icp;
      @(posedge ref_clk);
      #1;
    end
    cell_vld = 1'b0;
    cell_first = 1'b0;
    cell_last = 1'b0;
    if (st) begin
      n0 = dq[l].size();
      if (m_den[l])
        for (int k = lo; k <= 53; k++)
          if (cbuf[k] != last_cell[l][k]) dq[l].push_back({1'b0, 6'(k), cbuf[k]});
      if (dq[l].size() > n0) begin
        ent = dq[l].pop_back();
        dq[l].push_back(ent | 15'h4000);
      end
      for (int k = 1; k <= 53; k++) last_cell[l][k] = cbuf[k];
      m_wp[l] = m_wp[l] + 2'h1;
    end
    @(posedge ref_clk);
    #1;
  endtask

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == TMO) begin
      n_mismatch++;
      conclude();
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    logic [15:0] v;
    int          l;
    void'($urandom(37845));
    m_types = 32'h0;
    m_den = 16'h0;
    m_dbg = 2'h0;
    for (int i = 0; i < 16; i++) begin
      m_wp[i] = 2'h0;
      m_rp[i] = 2'h0;
      for (int k = 1; k <= 53; k++) last_cell[i][k] = 8'h00;
    end
    repeat (12) @(posedge ref_clk);
    #1;
    arst_n = 1'b1;
    foreach (RST_A[i]) rdcmp(RST_A[i], 16'h0000);
    v = 16'($urandom);
    wr(A_TYPE_HI, v);
    rdcmp(A_TYPE_HI, v);
    wr(A_DEBUG, 16'hFFC3);
    rdcmp(A_DEBUG, 16'h0003);
    wr(A_ADVANCE, 16'hFFFF);
    rdcmp(A_ADVANCE, 16'h0000);
    st_chk(5);
    // link n gets mode n mod 4, so links 8 and 9 differ in the low field
    m_types = 32'hE4E4E4E4;
    wr(A_TYPE_LO, m_types[15:0]);
    wr(A_TYPE_HI, m_types[31:16]);
    m_den = (16'($urandom) & 16'hFCFC) | 16'h0101;
    wr(A_DIFF_EN, m_den);
    rdcmp(A_DIFF_EN, m_den);
    wr(A_DEBUG, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      mk_cell(10);
      send_cell(10, 53, 1'b1, 1'b0);
      st_chk(10);
    end
    mk_cell(6);
    send_cell(6, 52, 1'b1, 1'b1);
    st_chk(6);
    mk_cell(8);
    send_cell(8, 53, 1'b1, 1'b1);
    send_cell(8, 53, 1'b1, 1'b1);
    st_chk(8);
    send_cell(9, 53, 1'b1, 1'b0);
    st_chk(9);
    send_cell(11, 53, 1'b1, 1'b1);
    st_chk(11);
    ne_chk();
    drain(8);
    // header-only change: skipped under icp scope, caught under whole-cell scope
    for (int d = 3; d >= 2; d--) begin
      m_dbg = 2'(d);
      wr(A_DEBUG, 16'(d));
      for (int k = 1; k <= 53; k++) cbuf[k] = last_cell[0][k];
      cbuf[2] = cbuf[2] ^ 8'h5A;
      send_cell(0, 53, 1'b1, 1'b1);
      st_chk(0);
    end
    drain(0);
    for (int n = 0; n < 150; n++) begin
      l = $urandom % 16;
      mk_cell(l);
      send_cell(l, ($urandom % 10 == 0) ? 52 : 53, $urandom % 8 != 0, 1'($urandom));
      if ($urandom % 3 == 0) adv(16'($urandom));
      if ($urandom % 4 == 0) st_chk($urandom % 16);
      if ($urandom % 5 == 0) drain($urandom % 16);
      if ($urandom % 8 == 0) begin
        m_dbg = 2'($urandom);
        wr(A_DEBUG, {14'h0000, m_dbg});
      end
      ne_chk();
    end
    for (int i = 0; i < 16; i++) begin
      st_chk(i);
      drain(i);
    end
    ne_chk();
    conclude();
  end
endmodule
`default_nettype wire
